// >>> logic/cco_pkg.sv
`default_nettype none
// Shared constants for the completion coalescing engine and its host end.
package cco_pkg;
    // Port count, command slots per port and field widths.
    localparam int unsigned NPORTS = 8;
    localparam int unsigned SLOTS = 32;
    localparam int unsigned SEL_W = 5;
    localparam int unsigned THR_W = 8;
    localparam int unsigned TV_W = 16;
    localparam int unsigned COUNT_W = 16;
    localparam int unsigned INC_W = 10;
    localparam int unsigned PC_W = 6;
    localparam int unsigned PORTINC_W = 7;
    localparam int unsigned TICK_W = 16;

    // Millisecond tick derived from the 50 MHz system clock.
    localparam int unsigned CLK_MHZ = 50;
    localparam int unsigned TICK_PERIOD_US = 1000;
    localparam int unsigned MS_TICK_CYCLES = TICK_PERIOD_US * CLK_MHZ;

    // Interrupt vector used when the programmed one would collide with a present port.
    localparam logic [SEL_W-1:0] DEFAULT_INT_SEL = 5'h08;

    // Register byte offsets on the Wishbone slave.
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_PORT_SELECT = 8'h04;
    localparam logic [7:0] OFS_PORTS_PRESENT = 8'h08;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h0C;
    localparam logic [7:0] OFS_GLOBAL = 8'h10;
    localparam logic [7:0] OFS_ENGINE_STATE = 8'h14;

    // Control, global and engine state register field positions.
    localparam int unsigned CTL_EN_BIT = 0;
    localparam int unsigned CTL_SEL_LSB = 3;
    localparam int unsigned CTL_THR_LSB = 8;
    localparam int unsigned CTL_TV_LSB = 16;
    localparam int unsigned GLB_GATE_BIT = 0;
    localparam int unsigned STATE_TIMER_LSB = 16;

    // Reset values.
    localparam logic [THR_W-1:0] RESET_THR = 8'h01;
    localparam logic [TV_W-1:0] RESET_TV = 16'h0001;

    // Engine running mode.
    typedef enum logic {
        MODE_OFF,
        MODE_RUN
    } cco_mode_t;
endpackage
`default_nettype wire

// >>> logic/cco_link_if.sv
`timescale 1ns/100ps
`default_nettype none
// Control and event wires between the host end and the coalescing engine.
interface cco_link_if;
    logic                                enable;
    logic [cco_pkg::THR_W-1:0]           completion_threshold;
    logic [cco_pkg::TV_W-1:0]            timeout_ms_value;
    logic [cco_pkg::SEL_W-1:0]           int_select;
    logic [cco_pkg::NPORTS-1:0]          coalesce_port_select;
    logic [cco_pkg::NPORTS-1:0]          ports_present;
    logic                                coal_event;
    logic [cco_pkg::SEL_W-1:0]           coal_vector;
    logic [cco_pkg::COUNT_W-1:0]         done_count;
    logic [cco_pkg::TV_W-1:0]            coalesce_timer;

    modport dev (
        input  enable, completion_threshold, timeout_ms_value, int_select,
        input  coalesce_port_select, ports_present,
        output coal_event, coal_vector, done_count, coalesce_timer
    );
    modport hst (
        output enable, completion_threshold, timeout_ms_value, int_select,
        output coalesce_port_select, ports_present,
        input  coal_event, coal_vector, done_count, coalesce_timer
    );
endinterface
`default_nettype wire

// >>> logic/cco_engine.sv
`timescale 1ns/100ps
`default_nettype none
module cco_engine #(
    parameter int unsigned PRESCALE_CYCLES = cco_pkg::MS_TICK_CYCLES
) (
    input  wire logic                                          CLK_SYS_I,
    input  wire logic                                          RESET_N_I,
    input  wire logic                                          CE_I,
    cco_link_if.dev                                            LINK,
    input  wire logic [cco_pkg::NPORTS-1:0][cco_pkg::SLOTS-1:0] CMD_ISSUE_I,
    input  wire logic [cco_pkg::NPORTS-1:0][cco_pkg::SLOTS-1:0] QUEUED_ACTIVE_I
);

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations.

    logic [cco_pkg::NPORTS-1:0][cco_pkg::SLOTS-1:0] prev_issue;
    logic [cco_pkg::NPORTS-1:0][cco_pkg::SLOTS-1:0] prev_queued;
    logic [cco_pkg::NPORTS-1:0]                     sel_ports;
    logic [cco_pkg::NPORTS-1:0][cco_pkg::PORTINC_W-1:0] port_inc;
    logic [cco_pkg::INC_W-1:0]                      total_inc;
    logic                                           outstanding;
    cco_pkg::cco_mode_t                             mode;
    logic                                           en_rise;
    logic [cco_pkg::THR_W-1:0]                      thr_q;
    logic [cco_pkg::TV_W-1:0]                       tv_q;
    logic [cco_pkg::TICK_W-1:0]                     tick_cnt;
    logic                                           tick;
    logic [cco_pkg::COUNT_W:0]                      sum_wide;
    logic [cco_pkg::COUNT_W-1:0]                    next_count;
    logic                                           thr_hit;
    logic                                           timer_hit;
    logic                                           drain_hit;
    logic                                           fire;
    logic                                           vec_clash;

    // Counts the set bits of one slot vector.
    function automatic logic [cco_pkg::PC_W-1:0] pop_slots(input logic [cco_pkg::SLOTS-1:0] v);
        logic [cco_pkg::PC_W-1:0] n;
        n = '0;
        for (int i = 0; i < cco_pkg::SLOTS; i++) begin
            n = n + cco_pkg::PC_W'(v[i]);
        end
        return n;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Completion detection.

    // Previous vectors are kept for every port so a port that is newly selected
    // has a valid history at once; selection then applies in the same cycle.
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            prev_issue <= '0;
            prev_queued <= '0;
        end else if (CE_I) begin
            prev_issue <= CMD_ISSUE_I;
            prev_queued <= QUEUED_ACTIVE_I;
        end
    end

    assign sel_ports = LINK.coalesce_port_select & LINK.ports_present;

    // Per-port completions: issue falls with queued low, or queued falls.
    generate
        for (genvar g = 0; g < cco_pkg::NPORTS; g++) begin : gen_port
            logic [cco_pkg::SLOTS-1:0] issue_fall;
            logic [cco_pkg::SLOTS-1:0] queued_fall;
            assign issue_fall = prev_issue[g] & ~CMD_ISSUE_I[g] & ~QUEUED_ACTIVE_I[g];
            assign queued_fall = prev_queued[g] & ~QUEUED_ACTIVE_I[g];
            assign port_inc[g] = sel_ports[g] ?
                ({1'b0, pop_slots(issue_fall)} + {1'b0, pop_slots(queued_fall)}) : '0;
        end
    endgenerate

    // Sum across ports and detect outstanding work on the selected set.
    always_comb begin
        total_inc = '0;
        outstanding = 1'b0;
        for (int i = 0; i < cco_pkg::NPORTS; i++) begin
            total_inc = total_inc + cco_pkg::INC_W'(port_inc[i]);
            outstanding = outstanding | (sel_ports[i] & ((|CMD_ISSUE_I[i]) | (|QUEUED_ACTIVE_I[i])));
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Millisecond prescaler.

    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            tick_cnt <= '0;
        end else if (CE_I) begin
            if (tick) begin
                tick_cnt <= '0;
            end else begin
                tick_cnt <= tick_cnt + cco_pkg::TICK_W'(1);
            end
        end
    end

    assign tick = (tick_cnt == cco_pkg::TICK_W'(PRESCALE_CYCLES - 1));

    ////////////////////////////////////////////////////////////////////////////////
    // Enable handling and captured fields.

    // The fields are captured only on the rising enable so a later careless
    // write cannot disturb a running window.
    assign en_rise = LINK.enable && (mode == cco_pkg::MODE_OFF);

    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            mode <= cco_pkg::MODE_OFF;
        end else if (CE_I) begin
            case (mode)
                cco_pkg::MODE_OFF: begin
                    if (LINK.enable) begin
                        mode <= cco_pkg::MODE_RUN;
                    end
                end
                cco_pkg::MODE_RUN: begin
                    if (!LINK.enable) begin
                        mode <= cco_pkg::MODE_OFF;
                    end
                end
                default: begin
                    mode <= cco_pkg::MODE_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            thr_q <= cco_pkg::RESET_THR;
            tv_q <= cco_pkg::RESET_TV;
        end else if (CE_I && en_rise) begin
            thr_q <= LINK.completion_threshold;
            tv_q <= LINK.timeout_ms_value;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt conditions.

    // The counter saturates instead of wrapping, so a huge burst never looks small.
    assign sum_wide = {1'b0, LINK.done_count} + (cco_pkg::COUNT_W + 1)'(total_inc);
    assign next_count = sum_wide[cco_pkg::COUNT_W] ? '1 : sum_wide[cco_pkg::COUNT_W-1:0];

    assign thr_hit = (thr_q != '0) && (next_count >= cco_pkg::COUNT_W'(thr_q));
    assign timer_hit = tick && outstanding && (LINK.coalesce_timer == cco_pkg::TV_W'(1));
    assign drain_hit = (total_inc != '0) && !outstanding && (thr_q != '0);
    assign fire = (mode == cco_pkg::MODE_RUN) && LINK.enable && (thr_hit || timer_hit || drain_hit);

    ////////////////////////////////////////////////////////////////////////////////
    // Completion counter and timer.

    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            LINK.done_count <= '0;
        end else if (CE_I) begin
            if (en_rise || fire) begin
                LINK.done_count <= '0;
            end else if (mode == cco_pkg::MODE_RUN) begin
                LINK.done_count <= next_count;
            end
        end
    end

    // hold when idle; zero never underflows.
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            LINK.coalesce_timer <= cco_pkg::RESET_TV;
        end else if (CE_I) begin
            if (en_rise) begin
                LINK.coalesce_timer <= LINK.timeout_ms_value;
            end else if (fire) begin
                LINK.coalesce_timer <= tv_q;
            end else if (mode == cco_pkg::MODE_RUN && tick && outstanding && LINK.coalesce_timer != '0) begin
                LINK.coalesce_timer <= LINK.coalesce_timer - cco_pkg::TV_W'(1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Event output toward the status logic.

    // fall back if index names a present port.
    assign vec_clash = (LINK.int_select < cco_pkg::SEL_W'(cco_pkg::NPORTS)) &&
                       LINK.ports_present[LINK.int_select[2:0]];

    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            LINK.coal_event <= 1'b0;
            LINK.coal_vector <= cco_pkg::DEFAULT_INT_SEL;
        end else if (CE_I) begin
            LINK.coal_event <= fire;
            if (fire) begin
                LINK.coal_vector <= vec_clash ? cco_pkg::DEFAULT_INT_SEL : LINK.int_select;
            end
        end
    end

endmodule
`default_nettype wire

// >>> logic/cco_host.sv
`timescale 1ns/100ps
`default_nettype none
// Host end: Wishbone registers, interrupt status and the global gate.
module cco_host (
    input  wire logic                          CLK_SYS_I,
    input  wire logic                          RESET_N_I,
    input  wire logic                          CE_I,
    cco_link_if.hst                            LINK,
    input  wire logic [cco_pkg::NPORTS-1:0]    PORTS_PRESENT_I,
    input  wire logic                          WB_CYC_I,
    input  wire logic                          WB_STB_I,
    input  wire logic                          WB_WE_I,
    input  wire logic [7:0]                    WB_ADR_I,
    input  wire logic [3:0]                    WB_SEL_I,
    input  wire logic [31:0]                   WB_DAT_I,
    output logic [31:0]                        WB_DAT_O,
    output logic                               WB_ACK_O,
    output logic                               IRQ_O,
    output logic                               MSI_O,
    output logic [cco_pkg::SEL_W-1:0]          MSI_VEC_O
);

    logic        wr;
    logic        gate;
    logic [31:0] irq_status_reg;
    logic [31:0] ctl_now;
    logic [31:0] ctl_new;
    logic [31:0] ps_new;
    logic [31:0] clr_bits;
    logic [31:0] set_bits;
    logic [31:0] rd_data;
    logic [cco_pkg::NPORTS-1:0] present_meta;

    // Merges written bytes over the old word under the byte lanes.
    function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Bus handshake: ack one cycle after the request, write at the ack edge.

    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= '0;
        end else if (CE_I) begin
            WB_ACK_O <= WB_CYC_I && WB_STB_I && !WB_ACK_O;
            if (WB_CYC_I && WB_STB_I && !WB_ACK_O) begin
                WB_DAT_O <= rd_data;
            end
        end
    end

    assign wr = WB_CYC_I && WB_STB_I && WB_WE_I && WB_ACK_O;

    assign ctl_now = {LINK.timeout_ms_value, LINK.completion_threshold, LINK.int_select, 2'h0, LINK.enable};
    assign ctl_new = lane_merge(ctl_now, WB_DAT_I, WB_SEL_I);
    assign ps_new = lane_merge({24'h0, LINK.coalesce_port_select}, WB_DAT_I, WB_SEL_I);

    // Readback; unmapped offsets read as zero.
    always_comb begin
        case (WB_ADR_I)
            cco_pkg::OFS_CONTROL:       rd_data = ctl_now;
            cco_pkg::OFS_PORT_SELECT:   rd_data = {24'h0, LINK.coalesce_port_select};
            cco_pkg::OFS_PORTS_PRESENT: rd_data = {24'h0, LINK.ports_present};
            cco_pkg::OFS_IRQ_STATUS:    rd_data = irq_status_reg;
            cco_pkg::OFS_GLOBAL:        rd_data = {31'h0, gate};
            cco_pkg::OFS_ENGINE_STATE:  rd_data = {LINK.coalesce_timer, LINK.done_count};
            default:                    rd_data = '0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Control registers.

    // Fields are frozen while enabled; a write then only moves the enable bit.
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            LINK.enable <= 1'b0;
            LINK.completion_threshold <= cco_pkg::RESET_THR;
            LINK.timeout_ms_value <= cco_pkg::RESET_TV;
            LINK.int_select <= cco_pkg::DEFAULT_INT_SEL;
        end else if (CE_I && wr && WB_ADR_I == cco_pkg::OFS_CONTROL) begin
            LINK.enable <= ctl_new[cco_pkg::CTL_EN_BIT];
            if (!LINK.enable) begin
                LINK.completion_threshold <= ctl_new[cco_pkg::CTL_THR_LSB +: cco_pkg::THR_W];
                LINK.timeout_ms_value <= ctl_new[cco_pkg::CTL_TV_LSB +: cco_pkg::TV_W];
                if (!(ctl_new[cco_pkg::CTL_SEL_LSB +: cco_pkg::SEL_W] < cco_pkg::SEL_W'(cco_pkg::NPORTS) &&
                      LINK.ports_present[ctl_new[cco_pkg::CTL_SEL_LSB +: 3]])) begin
                    LINK.int_select <= ctl_new[cco_pkg::CTL_SEL_LSB +: cco_pkg::SEL_W];
                end
            end
        end
    end

    // The strap comes from outside the clock domain, so it passes two flops before
    // any logic reads it; the first flop is read by nothing but the second.
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            present_meta <= '0;
            LINK.ports_present <= '0;
            LINK.coalesce_port_select <= '0;
            gate <= 1'b0;
        end else if (CE_I) begin
            present_meta <= PORTS_PRESENT_I;
            LINK.ports_present <= present_meta;
            if (wr && WB_ADR_I == cco_pkg::OFS_PORT_SELECT) begin
                LINK.coalesce_port_select <= ps_new[cco_pkg::NPORTS-1:0] & LINK.ports_present;
            end
            if (wr && WB_ADR_I == cco_pkg::OFS_GLOBAL && WB_SEL_I[0]) begin
                gate <= WB_DAT_I[cco_pkg::GLB_GATE_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt status, write one to clear; a same-cycle set wins.

    assign clr_bits = (wr && WB_ADR_I == cco_pkg::OFS_IRQ_STATUS) ? lane_merge('0, WB_DAT_I, WB_SEL_I) : '0;
    assign set_bits = LINK.coal_event ? (32'h1 << LINK.coal_vector) : '0;

    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            irq_status_reg <= '0;
            MSI_O <= 1'b0;
            MSI_VEC_O <= cco_pkg::DEFAULT_INT_SEL;
        end else if (CE_I) begin
            irq_status_reg <= (irq_status_reg & ~clr_bits) | set_bits;
            MSI_O <= LINK.coal_event && gate;
            if (LINK.coal_event) begin
                MSI_VEC_O <= LINK.coal_vector;
            end
        end
    end

    assign IRQ_O = gate && (|irq_status_reg);

endmodule
`default_nettype wire

// >>> bench/cco_link_properties.sv
`timescale 1ns/100ps
`default_nettype none
// Watches the link between host end and engine; the timer only moves for a stated cause, and the counter is checked only for its clears.
module cco_link_properties (
    input wire logic                         CLK_SYS_I,
    input wire logic                         RESET_N_I,
    input wire logic                         enable,
    input wire logic [cco_pkg::TV_W-1:0]     timeout_ms_value,
    input wire logic [cco_pkg::SEL_W-1:0]    int_select,
    input wire logic [cco_pkg::NPORTS-1:0]   ports_present,
    input wire logic                         coal_event,
    input wire logic [cco_pkg::SEL_W-1:0]    coal_vector,
    input wire logic [cco_pkg::COUNT_W-1:0]  done_count,
    input wire logic [cco_pkg::TV_W-1:0]     coalesce_timer
);
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!RESET_N_I);
    ////////////////////////////////////////////////////////////////////////////////
    // Firing empties the counter and rearms the timer in the same cycle as the pulse.
    a_event_clears_count: assert property (coal_event |-> done_count == 16'h0000)
        else $error("counter not cleared on event");
    a_event_reloads_timer: assert property (coal_event |-> coalesce_timer == timeout_ms_value)
        else $error("timer not reloaded on event");
    a_quiet_when_off: assert property ((!enable && !$past(enable)) |-> !coal_event)
        else $error("event while disabled");
    a_event_one_cycle: assert property (coal_event |=> !coal_event)
        else $error("event longer than one cycle");
    a_enable_rise_init: assert property ($rose(enable) |=> done_count == 16'h0000
        && coalesce_timer == timeout_ms_value)
        else $error("enable rise did not initialise");
    // A vector naming a present port is replaced by the default, so no port status is hit.
    a_vector_follows_sel: assert property (coal_event |-> coal_vector == ((int_select < 5'h08
        && ports_present[int_select[2:0]]) ? cco_pkg::DEFAULT_INT_SEL : int_select))
        else $error("wrong event vector");
    a_vector_not_port: assert property (coal_event |-> !(coal_vector < 5'h08
        && ports_present[coal_vector[2:0]]))
        else $error("vector names a present port");
    // Outside reloads the timer may only step down by one; it can never wrap below zero.
    a_timer_step_one: assert property ((enable && $past(enable, 2) && !coal_event
        && coalesce_timer != $past(coalesce_timer)) |-> coalesce_timer == $past(coalesce_timer) - 16'h0001)
        else $error("timer moved by other than one");
endmodule
`default_nettype wire

// >>> bench/tb_command_completion_coalescing.sv
`timescale 1ns/100ps
`default_nettype none
module tb_command_completion_coalescing;
    localparam int unsigned PRESCALE = 10;
    logic                                             clk_sys;
    logic                                             reset_n;
    logic [cco_pkg::NPORTS-1:0][cco_pkg::SLOTS-1:0]   ci;
    logic [cco_pkg::NPORTS-1:0][cco_pkg::SLOTS-1:0]   qa;
    logic                                             cyc, stb, we, ack, irq, msi;
    logic [7:0]                                       adr;
    logic [31:0]                                      wdat, dat_o, rdat;
    logic [cco_pkg::SEL_W-1:0]                        msi_vec;
    int                                               fail_count, comparisons, cycles, msi_count;
    cco_link_if i_cco_link_if ();
    // A short prescaler keeps millisecond waits to a few cycles.
    cco_engine #(.PRESCALE_CYCLES(PRESCALE)) i_cco_engine (.CLK_SYS_I(clk_sys), .RESET_N_I(reset_n),
        .CE_I(1'b1), .LINK(i_cco_link_if), .CMD_ISSUE_I(ci), .QUEUED_ACTIVE_I(qa));
    cco_host i_cco_host (.CLK_SYS_I(clk_sys), .RESET_N_I(reset_n), .CE_I(1'b1), .LINK(i_cco_link_if),
        .PORTS_PRESENT_I(8'h0F), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
        .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .IRQ_O(irq),
        .MSI_O(msi), .MSI_VEC_O(msi_vec));
    cco_link_properties i_cco_link_properties (.CLK_SYS_I(clk_sys), .RESET_N_I(reset_n),
        .enable(i_cco_link_if.enable), .timeout_ms_value(i_cco_link_if.timeout_ms_value),
        .int_select(i_cco_link_if.int_select), .ports_present(i_cco_link_if.ports_present),
        .coal_event(i_cco_link_if.coal_event), .coal_vector(i_cco_link_if.coal_vector),
        .done_count(i_cco_link_if.done_count), .coalesce_timer(i_cco_link_if.coalesce_timer));
    ////////////////////////////////////////////////////////////////////////////////
    // Clock at 50 MHz.
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    task automatic wrap_up();
        $display("mismatches %0d comparisons %0d", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One classic cycle; the request stands until ack is sampled high, then it is released.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
        do @(posedge clk_sys); while (ack !== 1'b1);
        rdat = dat_o;
        cyc <= 1'b0; stb <= 1'b0;
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // A hang costs a mismatch; the tests need well under the ceiling.
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            fail_count++;
            wrap_up();
        end
    end
    // The message pulse stands one cycle only, so every pulse is counted as it passes.
    always @(posedge clk_sys) begin
        if (msi === 1'b1) msi_count <= msi_count + 1;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Ports 0 to 3 are present; port 5 is absent and must never count.
    initial begin
        reset_n = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; wdat = 32'h0;
        ci = '0; qa = '0; fail_count = 0; comparisons = 0; cycles = 0; msi_count = 0;
        wait_n(16);
        reset_n <= 1'b1;
        // The present strap needs two edges through its synchroniser before it reads back.
        wait_n(2);
        bus(0, cco_pkg::OFS_PORTS_PRESENT, 32'h0); chk(rdat, 32'h0000_000F);
        // selection, timeout and threshold are set while off, then enabled.
        bus(1, cco_pkg::OFS_PORT_SELECT, 32'hFF); bus(0, cco_pkg::OFS_PORT_SELECT, 32'h0);
        chk(rdat, 32'h0000_000F);
        bus(1, cco_pkg::OFS_CONTROL, 32'h0064_0440); bus(1, cco_pkg::OFS_CONTROL, 32'h0064_0410);
        bus(0, cco_pkg::OFS_CONTROL, 32'h0); chk(rdat, 32'h0064_0440);
        bus(1, cco_pkg::OFS_GLOBAL, 32'h1);
        @(posedge clk_sys); ci[0] <= 32'h7; qa[1] <= 32'h7; ci[5] <= 32'h1;
        bus(1, cco_pkg::OFS_CONTROL, 32'h0064_0441);
        // Four qualifying falls in one cycle reach a threshold of four at once.
        @(posedge clk_sys); ci[0] <= 32'h4; qa[1] <= 32'h4; ci[5] <= 32'h0;
        wait_n(4); chk(i_cco_link_if.done_count, 16'h0000); chk(irq, 1'b1);
        chk(msi_vec, 5'h08); bus(0, cco_pkg::OFS_IRQ_STATUS, 32'h0); chk(rdat, 32'h100);
        bus(1, cco_pkg::OFS_IRQ_STATUS, 32'h100); bus(0, cco_pkg::OFS_IRQ_STATUS, 32'h0);
        chk(rdat, 32'h0);
        // An issue fall with its queued bit set is not a completion; the queued fall is.
        @(posedge clk_sys); qa[0] <= 32'h4;
        @(posedge clk_sys); ci[0] <= 32'h0;
        wait_n(3); chk(i_cco_link_if.done_count, 16'h0000);
        @(posedge clk_sys); qa[0] <= 32'h0;
        wait_n(3); chk(i_cco_link_if.done_count, 16'h0001);
        // Last outstanding command drains below threshold, which still fires.
        @(posedge clk_sys); qa[1] <= 32'h0;
        wait_n(4); chk(i_cco_link_if.done_count, 16'h0000); chk(irq, 1'b1);
        chk(msi_count, 32'h2);
        bus(1, cco_pkg::OFS_IRQ_STATUS, 32'h100);
        // Timeout of 3 ms with the gate closed: status sets but no interrupt leaves.
        bus(1, cco_pkg::OFS_GLOBAL, 32'h0); bus(1, cco_pkg::OFS_CONTROL, 32'h0003_0440);
        @(posedge clk_sys); ci[2] <= 32'h1;
        bus(1, cco_pkg::OFS_CONTROL, 32'h0003_0441);
        wait_n(16); bus(0, cco_pkg::OFS_IRQ_STATUS, 32'h0); chk(rdat, 32'h0);
        wait_n(20); bus(0, cco_pkg::OFS_IRQ_STATUS, 32'h0); chk(rdat, 32'h100);
        chk(irq, 1'b0);
        chk(msi_count, 32'h2);
        bus(1, cco_pkg::OFS_GLOBAL, 32'h1); wait_n(1); chk(irq, 1'b1);
        // Disabled: a completion neither counts nor raises anything.
        bus(1, cco_pkg::OFS_CONTROL, 32'h0003_0440); bus(1, cco_pkg::OFS_IRQ_STATUS, 32'h100);
        @(posedge clk_sys); ci[2] <= 32'h0;
        wait_n(40); bus(0, cco_pkg::OFS_IRQ_STATUS, 32'h0); chk(rdat, 32'h0);
        // port 2 leaves the selection after the engine has been disabled.
        bus(1, cco_pkg::OFS_PORT_SELECT, 32'h0B); bus(0, cco_pkg::OFS_PORT_SELECT, 32'h0);
        chk(rdat, 32'h0000_000B);
        bus(0, 8'h40, 32'h0); chk(rdat, 32'h0);
        wrap_up();
    end
endmodule
`default_nettype wire
